// >>> hdl/egt_defs.svh
// Constants for the edge and glitch trigger qualifier
// Notes on behaviour
// - Edge coupling AC, DC, low or high band suppress
// - Coupling read returns selected source's coupling
// - Slope positive, negative, either; kept per source
// - Mains line source takes no slope
// - Slope read returns selected source's slope
// - Edge source: analog, logic 0-15, aux, line, external
// - Analog index 1-2 or 1-4 by variant
// - External on two-channel, aux on four-channel only
// - Logic inputs only on mixed-signal variants
// - Source read returns current edge source
// - Glitch fires only below programmed width
// - Positive fires on fall, negative on rise
// - Glitch width spans 1.5 ns to 10 s; code holds at least one 100 ns clock cycle
// - Polarity positive or negative; source set separately
// - Polarity read returns held polarity
// - Glitch supports rearm delay and noise reject band
// - Edge fires on selected slope crossing level
`ifndef EGT_DEFS_SVH
`define EGT_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EGT_A_MODE      8'h00
`define EGT_A_EDGE_SRC  8'h04
`define EGT_A_EDGE_COUP 8'h08
`define EGT_A_EDGE_SLP  8'h0c
`define EGT_A_GL_POL    8'h10
`define EGT_A_GL_SRC    8'h14
`define EGT_A_GL_WIDTH  8'h18
`define EGT_A_REARM     8'h1c
`define EGT_A_NOISE     8'h20
`define EGT_A_STATUS    8'h24
`define EGT_A_NONE      8'hff

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define EGT_SRC_IDX_W   4
`define EGT_SRC_W       7
`define EGT_NSLOPE      22
`define EGT_NCOUP       5
`define EGT_SL_LOGIC0   5'h04
`define EGT_SL_AUX      5'h14
`define EGT_SL_EXT      5'h15
`define EGT_CP_EXT      3'h4
`define EGT_IN_EXT      5'h04
`define EGT_IN_AUX      5'h05
`define EGT_IN_LINE     5'h06
`define EGT_IN_LOGIC0   5'h07
`define EGT_NIN         23
`define EGT_SRC_RST     7'h01
`define EGT_GW_RST      32'h0000000a

// ****************************************************************
// Timing
// ****************************************************************
`define EGT_CLK_PS      100000
`define EGT_CLK_HZ      10000000
`define EGT_GW_MIN_PS   1500
`define EGT_GW_MAX_S    10
`define EGT_GW_MIN_RAW  ((`EGT_GW_MIN_PS + `EGT_CLK_PS - 1) / `EGT_CLK_PS)
`define EGT_GW_MIN_CYC  ((`EGT_GW_MIN_RAW < 1) ? 1 : `EGT_GW_MIN_RAW)
`define EGT_GW_MAX_CYC  (`EGT_GW_MAX_S * `EGT_CLK_HZ)

`endif

// >>> hdl/egt_pkg.sv
// Types for the edge and glitch trigger qualifier
`include "egt_defs.svh"
package egt_pkg;
  typedef enum logic {MD_EDGE = 1'b0, MD_GLITCH = 1'b1} egt_mode_t;
  typedef enum logic [2:0] {
    SRC_ANALOG = 3'h0,
    SRC_LOGIC  = 3'h1,
    SRC_AUX    = 3'h2,
    SRC_LINE   = 3'h3,
    SRC_EXT    = 3'h4
  } egt_kind_t;
  typedef enum logic [1:0] {
    CP_DC                 = 2'h0,
    CP_AC                 = 2'h1,
    CP_LOW_BAND_SUPPRESS  = 2'h2,
    CP_HIGH_BAND_SUPPRESS = 2'h3
  } egt_coup_t;
  typedef enum logic [1:0] {
    SL_POS    = 2'h0,
    SL_NEG    = 2'h1,
    SL_EITHER = 2'h2,
    SL_NONE   = 2'h3
  } egt_slope_t;
  typedef enum logic {GL_IDLE = 1'b0, GL_MEAS = 1'b1} egt_gstate_t;
  typedef struct packed {
    egt_mode_t                          mode;
    logic [`EGT_SRC_W-1:0]              edgeSrc;
    logic [`EGT_SRC_W-1:0]              glSrc;
    logic                               glPol;
    logic [`EGT_NSLOPE-1:0][1:0]        slope;
    logic [`EGT_NCOUP-1:0][1:0]         coup;
    logic [31:0]                        glWidth;
    logic [31:0]                        rearm_delay;
    logic                               noiseBand;
    logic [31:0]                        holdCnt;
    egt_gstate_t                        gst;
    logic [31:0]                        glCnt;
    logic                               prevRaw;
    logic                               filt;
    logic                               filtPrev;
    logic                               trig;
    logic [15:0]                        trigCount;
    egt_coup_t                          coupOut;
    logic                               wrPend;
    logic [7:0]                         addr;
    logic [31:0]                        hrdata;
    logic                               hreadyout;
    logic                               hresp;
  } egt_state_t;
endpackage : egt_pkg

// >>> hdl/egt_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module egt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import egt_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } egt_sync_t;

  egt_sync_t q;
  egt_sync_t next_q;
  logic [WIDTH-1:0] agree;

  generate
    if (WIDTH < 1)
    begin : gBadWidth
      $error("egt_sync WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second; the filter looks at stages two and three
  assign agree = q.s2 ~^ q.s3;

  always_comb
  begin
    next_q = q;
    next_q.s1 = din;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.out = (q.s3 & agree) | (q.out & ~agree);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else if (ce)
      q <= next_q;
  end

  assign dout = q.out;
endmodule : egt_sync
`default_nettype wire

// >>> hdl/egt_trigger.sv
// Edge and glitch trigger qualifier with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "egt_defs.svh"
module egt_trigger #(
  parameter int          NUM_CH     = 4,
  parameter int          HAS_LOGIC  = 1,
  parameter int unsigned GW_MAX_CYC = `EGT_GW_MAX_CYC
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire logic [3:0]      analogAbove,
  input  wire logic            extAbove,
  input  wire logic            auxAbove,
  input  wire logic            lineAbove,
  input  wire logic [15:0]     logicIn,
  output logic                 trigPulse,
  output egt_pkg::egt_coup_t   couplingSel
);
  import egt_pkg::*;

  localparam int unsigned GW_MIN_CYC = `EGT_GW_MIN_CYC;

  egt_state_t              q;
  egt_state_t              next_q;
  logic [`EGT_NIN-1:0]     rawIn;
  logic [`EGT_NIN-1:0]     syncIn;
  logic                    edgeRise;
  logic                    edgeFall;
  logic                    actRise;
  logic                    actFall;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (!(NUM_CH == 2 || NUM_CH == 4) || GW_MAX_CYC < GW_MIN_CYC || GW_MAX_CYC < `EGT_GW_RST)
    begin : gBadParam
      $error("egt_trigger: NUM_CH must be 2 or 4 and GW_MAX_CYC above minimum");
    end
  endgenerate

  // ****************************************************************
  // Source helpers
  // ****************************************************************
  function automatic logic srcOk(logic [`EGT_SRC_W-1:0] s, logic glitch);
    logic ok;
    ok = 1'b0;
    case (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W])
      SRC_ANALOG: ok = (s[3:0] >= 4'h1) && (s[3:0] <= 4'(NUM_CH));
      SRC_LOGIC:  ok = (HAS_LOGIC != 0);
      SRC_AUX:    ok = !glitch && (NUM_CH == 4);
      SRC_LINE:   ok = !glitch;
      SRC_EXT:    ok = (NUM_CH == 2);
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction : srcOk

  function automatic logic [4:0] slopeIdx(logic [`EGT_SRC_W-1:0] s);
    logic [4:0] i;
    i = 5'h00;
    case (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W])
      SRC_ANALOG: i = 5'(s[3:0]) - 5'h01;
      SRC_LOGIC:  i = `EGT_SL_LOGIC0 + 5'(s[3:0]);
      SRC_AUX:    i = `EGT_SL_AUX;
      SRC_EXT:    i = `EGT_SL_EXT;
      default:    i = 5'h00;
    endcase
    return i;
  endfunction : slopeIdx

  function automatic logic hasCoup(logic [`EGT_SRC_W-1:0] s);
    return (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W] == SRC_ANALOG) ||
           (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W] == SRC_EXT);
  endfunction : hasCoup

  function automatic logic [2:0] coupIdx(logic [`EGT_SRC_W-1:0] s);
    logic [2:0] i;
    i = (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W] == SRC_EXT) ? `EGT_CP_EXT : 3'(s[3:0] - 4'h1);
    return i;
  endfunction : coupIdx

  function automatic logic pick(logic [`EGT_SRC_W-1:0] s, logic [`EGT_NIN-1:0] v);
    logic b;
    b = 1'b0;
    case (s[`EGT_SRC_W-1:`EGT_SRC_IDX_W])
      SRC_ANALOG: b = v[5'(s[3:0]) - 5'h01];
      SRC_LOGIC:  b = v[`EGT_IN_LOGIC0 + 5'(s[3:0])];
      SRC_AUX:    b = v[`EGT_IN_AUX];
      SRC_LINE:   b = v[`EGT_IN_LINE];
      SRC_EXT:    b = v[`EGT_IN_EXT];
      default:    b = 1'b0;
    endcase
    return b;
  endfunction : pick

  function automatic logic [31:0] rdMux(egt_state_t s, logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    case (a)
      `EGT_A_MODE:      d = {31'h0, s.mode};
      `EGT_A_EDGE_SRC:  d = {25'h0, s.edgeSrc};
      `EGT_A_EDGE_COUP: d = hasCoup(s.edgeSrc) ? {30'h0, s.coup[coupIdx(s.edgeSrc)]}
                                               : {30'h0, CP_DC};
      `EGT_A_EDGE_SLP:  d = (s.edgeSrc[6:4] == SRC_LINE) ? {30'h0, SL_NONE}
                                                         : {30'h0, s.slope[slopeIdx(s.edgeSrc)]};
      `EGT_A_GL_POL:    d = {31'h0, s.glPol};
      `EGT_A_GL_SRC:    d = {25'h0, s.glSrc};
      `EGT_A_GL_WIDTH:  d = s.glWidth;
      `EGT_A_REARM:     d = s.rearm_delay;
      `EGT_A_NOISE:     d = {31'h0, s.noiseBand};
      `EGT_A_STATUS:    d = {14'h0, s.gst, (s.holdCnt != 32'h0), s.trigCount};
      default:          d = 32'h00000000;
    endcase
    return d;
  endfunction : rdMux

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  assign rawIn = {logicIn, lineAbove, auxAbove, extAbove, analogAbove};

  egt_sync #(
    .WIDTH (`EGT_NIN)
  ) uSync (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .din   (rawIn),
    .dout  (syncIn)
  );

  assign edgeRise = q.filt & ~q.filtPrev;
  assign edgeFall = ~q.filt & q.filtPrev;
  assign actRise  = q.glPol ? edgeFall : edgeRise;
  assign actFall  = q.glPol ? edgeRise : edgeFall;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    logic [`EGT_SRC_W-1:0] src;
    logic                  raw;
    logic                  eFire;
    logic                  gFire;
    logic                  fire;
    egt_slope_t            sl;
    src   = '0;
    raw   = 1'b0;
    eFire = 1'b0;
    gFire = 1'b0;
    fire  = 1'b0;
    sl    = SL_POS;
    next_q = q;

    // Write data phase; mode ordering is left to the host
    if (q.wrPend)
    begin
      case (q.addr)
        `EGT_A_MODE:      next_q.mode = egt_mode_t'(hwdata[0]);
        `EGT_A_EDGE_SRC:
        begin
          if (srcOk(hwdata[6:0], 1'b0))
            next_q.edgeSrc = hwdata[6:0];
        end
        `EGT_A_EDGE_COUP:
        begin
          if (hasCoup(q.edgeSrc))
            next_q.coup[coupIdx(q.edgeSrc)] = hwdata[1:0];
        end
        `EGT_A_EDGE_SLP:
        begin
          if (q.edgeSrc[6:4] != SRC_LINE && hwdata[1:0] != SL_NONE)
            next_q.slope[slopeIdx(q.edgeSrc)] = hwdata[1:0];
        end
        `EGT_A_GL_POL:    next_q.glPol = hwdata[0];
        `EGT_A_GL_SRC:
        begin
          if (srcOk(hwdata[6:0], 1'b1))
            next_q.glSrc = hwdata[6:0];
        end
        `EGT_A_GL_WIDTH:
        begin
          if (hwdata < 32'(GW_MIN_CYC))
            next_q.glWidth = 32'(GW_MIN_CYC);
          else if (hwdata > 32'(GW_MAX_CYC))
            next_q.glWidth = 32'(GW_MAX_CYC);
          else
            next_q.glWidth = hwdata;
        end
        `EGT_A_REARM:     next_q.rearm_delay = hwdata;
        `EGT_A_NOISE:     next_q.noiseBand = hwdata[0];
        default:          next_q.mode = q.mode;
      endcase
    end

    // Address phase; sub-word writes are dropped
    next_q.wrPend = hsel && htrans[1] && hready && hwrite && (hsize == 3'h2);
    next_q.addr   = (haddr[31:8] == 24'h0) ? haddr[7:0] : `EGT_A_NONE;

    // Source select and optional noise reject band
    src = (q.mode == MD_GLITCH) ? q.glSrc : q.edgeSrc;
    raw = pick(src, syncIn);
    next_q.prevRaw  = raw;
    next_q.filt     = (!q.noiseBand || raw == q.prevRaw) ? raw : q.filt;
    next_q.filtPrev = q.filt;

    // Edge qualification; the mains line ignores the slope
    sl = egt_slope_t'(q.slope[slopeIdx(q.edgeSrc)]);
    if (q.edgeSrc[6:4] == SRC_LINE)
      eFire = edgeRise;
    else
    begin
      case (sl)
        SL_POS:    eFire = edgeRise;
        SL_NEG:    eFire = edgeFall;
        SL_EITHER: eFire = edgeRise | edgeFall;
        default:   eFire = 1'b0;
      endcase
    end

    // Glitch width measurement in clock cycles
    case (q.gst)
      GL_IDLE:
      begin
        if (q.mode == MD_GLITCH && actRise)
        begin
          next_q.gst   = GL_MEAS;
          next_q.glCnt = 32'h00000001;
        end
      end
      GL_MEAS:
      begin
        if (q.mode != MD_GLITCH)
          next_q.gst = GL_IDLE;
        else if (actFall)
        begin
          next_q.gst = GL_IDLE;
          gFire      = (q.glCnt < q.glWidth);
        end
        else if (q.glCnt != 32'hffffffff)
          next_q.glCnt = q.glCnt + 32'h00000001;
      end
      default: next_q.gst = GL_IDLE;
    endcase

    // Rearm delay blocks triggers after each one
    fire = ((q.mode == MD_GLITCH) ? gFire : eFire) && (q.holdCnt == 32'h0);
    if (fire)
    begin
      next_q.holdCnt   = next_q.rearm_delay;
      next_q.trigCount = q.trigCount + 16'h0001;
    end
    else if (q.holdCnt != 32'h0)
      next_q.holdCnt = q.holdCnt - 32'h00000001;
    next_q.trig = fire;

    next_q.coupOut   = hasCoup(next_q.edgeSrc) ?
                       egt_coup_t'(next_q.coup[coupIdx(next_q.edgeSrc)]) : CP_DC;
    next_q.hrdata    = rdMux(next_q, next_q.addr);
    next_q.hreadyout = 1'b1;
    next_q.hresp     = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q           <= '0;
      q.edgeSrc   <= `EGT_SRC_RST;
      q.glSrc     <= `EGT_SRC_RST;
      q.glWidth   <= `EGT_GW_RST;
      q.hreadyout <= 1'b1;
    end
    else if (ce)
      q <= next_q;
  end

  assign hrdata      = q.hrdata;
  assign hreadyout   = q.hreadyout;
  assign hresp       = q.hresp;
  assign trigPulse   = q.trig;
  assign couplingSel = q.coupOut;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_TRIG_ONE: assert property (ce && q.trig |=> !q.trig)
    else $error("Trigger pulse longer than one cycle");

  AST_EDGE_POS: assert property (ce && q.mode == MD_EDGE && q.edgeSrc[6:4] != SRC_LINE &&
    q.slope[slopeIdx(q.edgeSrc)] == SL_POS && edgeRise && q.holdCnt == 32'h0
    |=> q.trig)
    else $error("Positive edge not triggered");

  AST_HOLD_BLOCK: assert property (ce && q.holdCnt != 32'h0 |=> !q.trig)
    else $error("Trigger during rearm delay");

  AST_HOLD_LOAD: assert property (q.trig |-> q.holdCnt == q.rearm_delay)
    else $error("Rearm delay not loaded on trigger");

  AST_GL_WIDE: assert property (ce && q.mode == MD_GLITCH && q.gst == GL_MEAS && actFall &&
    q.glCnt >= q.glWidth |=> !q.trig)
    else $error("Glitch trigger on wide pulse");

  AST_GL_NARROW: assert property (ce && q.mode == MD_GLITCH && q.gst == GL_MEAS && actFall &&
    q.glCnt < q.glWidth && q.holdCnt == 32'h0 |=> q.trig)
    else $error("Narrow glitch not triggered");

  AST_SRC_OK: assert property (srcOk(q.edgeSrc, 1'b0) && srcOk(q.glSrc, 1'b1))
    else $error("Illegal trigger source held");

  AST_GW_RANGE: assert property (q.glWidth >= 32'(GW_MIN_CYC) &&
    q.glWidth <= 32'(GW_MAX_CYC))
    else $error("Glitch width out of range");

  AST_COUP_OUT: assert property (!hasCoup(q.edgeSrc) |-> q.coupOut == CP_DC)
    else $error("Coupling driven for source without coupling");

  AST_READY: assert property (hreadyout && !hresp)
    else $error("Slave not ready or error response");

  COV_EDGE: cover property (q.mode == MD_EDGE && q.trig);
  COV_GLITCH: cover property (q.mode == MD_GLITCH && q.trig);
  COV_HOLD: cover property (ce && q.holdCnt != 32'h0 && q.gst == GL_MEAS && actFall);
endmodule : egt_trigger
`default_nettype wire

// >>> sim/egt_front_model.sv
// Comparator-level model of the inputs feeding the trigger qualifier
`timescale 1ns/10ps
`default_nettype none
module egt_front_model (
  input  wire logic        mclk,
  output logic      [3:0]  analogAbove,
  output logic             extAbove,
  output logic             auxAbove,
  output logic             lineAbove,
  output logic      [15:0] logicIn
);
  // ********
  // Pin levels
  // ********
  // Index order matches the qualifier: ch1-4, ext, aux, line, logic 0-15
  logic [22:0] lvl = 23'h0;
  assign {logicIn, lineAbove, auxAbove, extAbove, analogAbove} = lvl;
  // Levels change only on rising mclk edges; the qualifier has to synchronise them itself
  task automatic setPin(input int pin, input logic v);
    @(posedge mclk);
    lvl[pin] <= v;
  endtask : setPin
endmodule : egt_front_model
`default_nettype wire

// >>> sim/egt_trigger_bench.sv
// Self-checking bench for the edge and glitch trigger qualifier
`timescale 1ns/10ps
`default_nettype none
`include "egt_defs.svh"
module egt_trigger_bench;
  import egt_pkg::*;
  localparam int GWMAX = 200;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  analogAbove;
  logic        extAbove;
  logic        auxAbove;
  logic        lineAbove;
  logic [15:0] logicIn;
  logic        trigPulse;
  egt_coup_t   couplingSel;
  logic [31:0] q;
  int          fail_count = 0;
  int          tests_run = 0;
  int          trigSeen = 0;
  int          mSrc = 1;
  int          mCount = 0;
  int          c;
  int          mSlope[128];
  int          mCoup[128];
  logic [7:0]  rA[9] = '{`EGT_A_MODE, `EGT_A_EDGE_SRC, `EGT_A_EDGE_COUP, `EGT_A_EDGE_SLP,
                         `EGT_A_GL_POL, `EGT_A_GL_SRC, `EGT_A_GL_WIDTH, `EGT_A_STATUS,
                         `EGT_A_NONE};
  int          rV[9] = '{0, 1, 0, 0, 0, 1, 10, 0, 0};
  int          srcTab[11] = '{1, 2, 3, 4, 5, 0, 16, 31, 32, 48, 64};
  int          slTab[7] = '{1, 2, 3, 4, 16, 31, 32};
  int          edTab[3] = '{2, 21, 32};
  int          nTab[4] = '{3, 7, 8, 12};

  always #50 mclk = ~mclk;
  always @(posedge mclk) if (trigPulse === 1'b1) trigSeen <= trigSeen + 1;

  egt_trigger #(.NUM_CH(4), .HAS_LOGIC(1), .GW_MAX_CYC(GWMAX)) egt_trigger_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .analogAbove(analogAbove), .extAbove(extAbove),
    .auxAbove(auxAbove), .lineAbove(lineAbove), .logicIn(logicIn), .trigPulse(trigPulse),
    .couplingSel(couplingSel));
  egt_front_model fe_inst (
    .mclk(mclk), .analogAbove(analogAbove), .extAbove(extAbove), .auxAbove(auxAbove),
    .lineAbove(lineAbove), .logicIn(logicIn));

  // ********
  // Checking and closing
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // ********
  // Bus master and model helpers
  // ********
  task automatic waitRdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        fail_count++;
        finish_test;
      end
      @(posedge mclk);
    end
  endtask : waitRdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    waitRdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    q = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask : rdc
  // Pulse of n cycles; triggers counted while active and after it ends
  task automatic tryPulse(input int pin, input logic pol, input int n, input int eLead,
                          input int eTrail);
    int t0;
    int t1;
    t0 = trigSeen;
    fe_inst.setPin(pin, pol);
    repeat (n - 1) @(posedge mclk);
    t1 = trigSeen;
    fe_inst.setPin(pin, !pol);
    repeat (15) @(posedge mclk);
    check(t1 - t0, eLead);
    check(trigSeen - t1, eTrail);
    mCount += eLead + eTrail;
  endtask : tryPulse
  function automatic bit legal(input int s);
    return (s >> 4 == 0 && s % 16 >= 1 && s % 16 <= 4) || s >> 4 == 1 || s == 32 || s == 48;
  endfunction : legal
  function automatic int pinOf(input int s);
    return (s >> 4 == 0) ? s - 1 : (s >> 4 == 1) ? 7 + s % 16 : (s == 32) ? 5 : 6;
  endfunction : pinOf

  // ********
  // Main sequence
  // ********
  initial
  begin
    void'($urandom(32'hc774));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    foreach (rA[i]) rdc(rA[i], rV[i]);
    check({30'h0, couplingSel}, 32'h0);
    $display("Done: reset values");
    wr(`EGT_A_MODE, 0);
    for (int i = 0; i < 17; i++)
    begin
      c = (i < 11) ? srcTab[i] : $urandom_range(0, 31);
      wr(`EGT_A_EDGE_SRC, c);
      if (legal(c))
        mSrc = c;
      rdc(`EGT_A_EDGE_SRC, mSrc);
    end
    $display("Done: edge sources");
    foreach (slTab[i])
    begin
      wr(`EGT_A_EDGE_SRC, slTab[i]);
      mSlope[slTab[i]] = $urandom_range(0, 2);
      wr(`EGT_A_EDGE_SLP, mSlope[slTab[i]]);
      wr(`EGT_A_EDGE_SLP, 3);
      rdc(`EGT_A_EDGE_SLP, mSlope[slTab[i]]);
    end
    wr(`EGT_A_EDGE_SRC, 48);
    wr(`EGT_A_EDGE_SLP, 1);
    rdc(`EGT_A_EDGE_SLP, 3);
    foreach (slTab[i])
    begin
      wr(`EGT_A_EDGE_SRC, slTab[i]);
      rdc(`EGT_A_EDGE_SLP, mSlope[slTab[i]]);
    end
    $display("Done: slopes");
    for (int ch = 1; ch <= 4; ch++)
    begin
      mCoup[ch] = $urandom_range(0, 3);
      wr(`EGT_A_EDGE_SRC, ch);
      wr(`EGT_A_EDGE_COUP, mCoup[ch]);
    end
    for (int ch = 4; ch >= 1; ch--)
    begin
      wr(`EGT_A_EDGE_SRC, ch);
      rdc(`EGT_A_EDGE_COUP, mCoup[ch]);
      check({30'h0, couplingSel}, mCoup[ch]);
    end
    wr(`EGT_A_EDGE_SRC, 21);
    wr(`EGT_A_EDGE_COUP, 3);
    repeat (2) @(posedge mclk);
    check({30'h0, couplingSel}, 32'h0);
    $display("Done: coupling");
    foreach (edTab[i])
      for (int s = 0; s < 3; s++)
      begin
        wr(`EGT_A_EDGE_SRC, edTab[i]);
        wr(`EGT_A_EDGE_SLP, s);
        tryPulse(pinOf(edTab[i]), 1'b1, 20, s != 1, s != 0);
      end
    wr(`EGT_A_EDGE_SRC, 48);
    tryPulse(6, 1'b1, 20, 1, 0);
    ce <= 1'b0;
    tryPulse(6, 1'b1, 20, 0, 0);
    ce <= 1'b1;
    $display("Done: edge triggering");
    wr(`EGT_A_MODE, 1);
    wr(`EGT_A_GL_SRC, 3);
    rdc(`EGT_A_GL_SRC, 3);
    wr(`EGT_A_GL_SRC, 48);
    rdc(`EGT_A_GL_SRC, 3);
    wr(`EGT_A_GL_WIDTH, 0);
    rdc(`EGT_A_GL_WIDTH, 1);
    wr(`EGT_A_GL_WIDTH, 1000);
    rdc(`EGT_A_GL_WIDTH, GWMAX);
    wr(`EGT_A_GL_WIDTH, 8);
    wr(`EGT_A_REARM, 40);
    tryPulse(2, 1'b1, 3, 0, 1);
    tryPulse(2, 1'b1, 3, 0, 0);
    repeat (40) @(posedge mclk);
    tryPulse(2, 1'b1, 3, 0, 1);
    wr(`EGT_A_REARM, 0);
    // Delay loaded by the last trigger still has to run out
    repeat (40) @(posedge mclk);
    wr(`EGT_A_NOISE, 1);
    rdc(`EGT_A_NOISE, 1);
    tryPulse(2, 1'b1, 4, 0, 1);
    wr(`EGT_A_NOISE, 0);
    for (int p = 0; p < 2; p++)
    begin
      wr(`EGT_A_GL_POL, p);
      rdc(`EGT_A_GL_POL, p);
      repeat (20) @(posedge mclk);
      fe_inst.setPin(2, p[0]);
      repeat (20) @(posedge mclk);
      foreach (nTab[i]) tryPulse(2, !p[0], nTab[i], 0, nTab[i] < 8);
    end
    fe_inst.setPin(2, 1'b0);
    repeat (10) @(posedge mclk);
    bus(1'b0, `EGT_A_STATUS, 32'h0);
    check({16'h0, q[15:0]}, mCount);
    check({30'h0, q[17:16]}, 32'h2);
    $display("Done: glitch triggering");
    finish_test;
  end

  initial
  begin
    #(100 * 60000);
    fail_count++;
    finish_test;
  end
endmodule : egt_trigger_bench
`default_nettype wire
